/* sio_pkg.sv */
// constants, types and register map shared by the serial i/o scheduler
package sio_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NUM_DEV = 64;
  localparam int NUM_PORT = 128;
  localparam int FIFO_DEPTH = 16;
  localparam logic [5:0] LAST_DEV = 6'h3F;
  localparam logic [13:0] BRK_ROUNDS_M1 = 14'h3FFF;
  localparam logic [1:0] FAIL_LIMIT_M1 = 2'h2;
  localparam logic [1:0] DATA_TRY_M1 = 2'h2;

  // ------------------------------------------------------------
  // host address map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [9:0] A_CMD_STAT = 10'h000;
  localparam logic [9:0] A_CFG = 10'h002;
  localparam logic [9:0] A_TXF_LO = 10'h006;
  localparam logic [9:0] A_TXF_HI = 10'h007;
  localparam logic [9:0] A_RXF = 10'h008;
  localparam logic [9:0] A_FAULT = 10'h010;
  localparam logic [1:0] AREA_REG = 2'h0;
  localparam logic [1:0] AREA_INFO = 2'h1;
  localparam logic [1:0] AREA_CHG = 2'h2;
  localparam logic [1:0] AREA_PORT = 2'h3;

  // ------------------------------------------------------------
  // commands, status and config bits
  // ------------------------------------------------------------
  localparam logic [15:0] CMD_POLL = 16'h1000;
  localparam logic [15:0] CMD_CYC_START = 16'h3000;
  localparam logic [15:0] CMD_CYC_STOP = 16'h3100;
  localparam logic [9:0] CMD_SEND_HI = 10'h100;
  localparam int ST_DONE = 0;
  localparam int ST_BRK = 1;
  localparam int ST_CHG = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_RXP = 10;
  localparam int ST_CYC = 12;
  localparam int ST_POLL = 13;
  localparam int CFG_NOBRK = 8;
  localparam int INF_USE = 0;
  localparam int INF_DATA = 1;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    K_POLL = 2'b00,
    K_CYC = 2'b01,
    K_DATA = 2'b10,
    K_BRK = 2'b11
  } sio_kind_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01
  } sio_state_t;

  typedef struct packed {
    sio_kind_t kind;
    logic [5:0] dev;
  } sio_req_t;

  typedef struct packed {
    logic ok;
    logic break_detect_flag;
    logic [7:0] info;
    logic [7:0] port0;
    logic [7:0] port1;
  } sio_rsp_t;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic bus8;
    logic [9:0] addr;
    logic [15:0] data;
  } sio_host_t;

endpackage : sio_pkg

/* sio_sync.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module sio_sync #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  // idle pins are high so strobes come out inactive
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '1;
      o_q <= '1;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule : sio_sync
`default_nettype wire

/* sio_fifo.sv */
// flip-flop fifo with clear and a rewind mark for resending
`timescale 1ns/1ps
`default_nettype none
module sio_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_clr,
  input wire logic i_push,
  input wire logic [W-1:0] i_wdata,
  input wire logic i_pop,
  input wire logic i_mark,
  input wire logic i_rewind,
  output logic [W-1:0] o_head,
  output logic o_empty,
  output logic o_full
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0] wp_q, rp_q, mk_q;

  assign o_empty = (wp_q == rp_q);
  assign o_full = (wp_q == {~rp_q[AW], rp_q[AW-1:0]});
  assign o_head = mem_q[rp_q[AW-1:0]];

  always_ff @(posedge i_mclk) begin
    if (i_push && !o_full) begin
      mem_q[wp_q[AW-1:0]] <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      mk_q <= '0;
    end else if (i_clr) begin
      wp_q <= '0;
      rp_q <= '0;
      mk_q <= '0;
    end else begin
      if (i_push && !o_full) begin
        wp_q <= wp_q + 1'b1;
      end
      if (i_mark) begin
        mk_q <= rp_q;
      end
      // a rewind replays the words since the mark
      if (i_rewind) begin
        rp_q <= mk_q;
      end else if (i_pop && !o_empty) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule : sio_fifo
`default_nettype wire

/* sio_sched.sv */
// communication scheduler of the serial i/o master
`timescale 1ns/1ps
`default_nettype none
module sio_sched (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire sio_pkg::sio_host_t i_host,
  output logic [15:0] o_d_q,
  output logic o_d_oe_n_q,
  output logic o_irq_q,
  output sio_pkg::sio_req_t o_req_q,
  output logic o_req_valid_q,
  input wire logic i_rsp_valid,
  input wire sio_pkg::sio_rsp_t i_rsp,
  input wire logic i_tx_pop,
  output logic [15:0] o_tx_word_q,
  output logic o_tx_empty_q,
  input wire logic i_rx_valid,
  input wire logic [15:0] i_rx_word
);
  import sio_pkg::*;

  // ------------------------------------------------------------
  // host pins
  // ------------------------------------------------------------
  sio_host_t hs;
  logic wr_act_q, rd_act_q, wr_done, rd_done;
  logic [9:0] la_q;
  logic [15:0] ld_q;
  logic l8_q;
  logic [7:0] lo_byte_q;

  sio_sync #(.W($bits(sio_host_t))) u_sync (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_d(i_host), .o_q(hs)
  );

  wire wr_now = !hs.cs_n && !hs.wr_n;
  wire rd_now = !hs.cs_n && !hs.rd_n;
  assign wr_done = wr_act_q && !wr_now;
  assign rd_done = rd_act_q && !rd_now;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      la_q <= '0;
      ld_q <= '0;
      l8_q <= 1'b0;
    end else begin
      wr_act_q <= wr_now;
      rd_act_q <= rd_now;
      if (wr_now || rd_now) begin
        la_q <= hs.addr;
        ld_q <= hs.data;
        l8_q <= hs.bus8;
      end
    end
  end

  wire [1:0] area = la_q[9:8];
  wire [5:0] adev = la_q[6:1];
  wire [2:0] aword = la_q[3:1];
  wire wr_reg = wr_done && (area == AREA_REG);
  wire cmd_wr = wr_reg && (la_q == A_CMD_STAT);
  wire send_cmd = cmd_wr && (ld_q[15:6] == CMD_SEND_HI);
  wire wr_info = wr_done && (area == AREA_INFO);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  sio_state_t st_q;
  logic [7:0] info_q [NUM_DEV];
  logic [7:0] port_q [NUM_PORT];
  logic [NUM_PORT-1:0] chg_en_q, chg_q;
  logic [NUM_DEV-1:0] fault_q;
  logic [1:0] fail_q [NUM_DEV];
  logic [15:0] cfg_q;
  logic done_q, brk_q;
  logic cyc_run_q, poll_pend_q, data_pend_q, round_ok_q, brk_due_q;
  logic [5:0] poll_idx_q, data_dev_q, cyc_dev_q;
  logic [1:0] retry_q;
  logic [13:0] round_cnt_q;
  logic tx_empty, rx_empty, tx_full, rx_full;
  logic [15:0] tx_head, rx_head;

  // next in-use device above cur, else lowest in-use
  function automatic logic [6:0] next_dev(input logic [63:0] use_v, input logic [5:0] cur);
    logic [6:0] lo, hi;
    lo = '0;
    hi = '0;
    for (int i = NUM_DEV - 1; i >= 0; i--) begin
      if (use_v[i]) begin
        lo = {1'b1, 6'(i)};
        if (6'(i) > cur) begin
          hi = {1'b1, 6'(i)};
        end
      end
    end
    return hi[6] ? hi : lo;
  endfunction : next_dev

  logic [NUM_DEV-1:0] use_v;
  always_comb begin
    for (int i = 0; i < NUM_DEV; i++) begin
      use_v[i] = info_q[i][INF_USE];
    end
  end
  wire [6:0] nxt = next_dev(use_v, cyc_dev_q);
  wire rsp_in = (st_q == S_WAIT) && i_rsp_valid;
  wire rsp_poll = rsp_in && (o_req_q.kind == K_POLL);
  wire rsp_cyc = rsp_in && (o_req_q.kind == K_CYC);
  wire rsp_data = rsp_in && (o_req_q.kind == K_DATA);
  wire rsp_brk = rsp_in && (o_req_q.kind == K_BRK);
  wire go_data = cyc_run_q && data_pend_q && round_ok_q;
  wire go_brk = cyc_run_q && brk_due_q && !cfg_q[CFG_NOBRK];
  wire issue = (st_q == S_IDLE) && (poll_pend_q || go_data || go_brk || (cyc_run_q && nxt[6]));
  wire issue_data = issue && !poll_pend_q && go_data;
  wire data_fail_end = rsp_data && !i_rsp.ok && (retry_q == DATA_TRY_M1);
  wire data_rewind = rsp_data && !i_rsp.ok && (retry_q != DATA_TRY_M1);

  // ------------------------------------------------------------
  // scheduler
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= S_IDLE;
      o_req_q <= '0;
      o_req_valid_q <= 1'b0;
      cyc_run_q <= 1'b0;
      poll_pend_q <= 1'b0;
      poll_idx_q <= '0;
      cyc_dev_q <= LAST_DEV;
      round_ok_q <= 1'b0;
      round_cnt_q <= '0;
      brk_due_q <= 1'b0;
    end else begin
      o_req_valid_q <= 1'b0;
      if (cmd_wr && ld_q == CMD_POLL) begin
        poll_pend_q <= 1'b1;
        poll_idx_q <= '0;
      end
      if (cmd_wr && ld_q == CMD_CYC_START) begin
        cyc_run_q <= 1'b1;
      end
      if (cmd_wr && ld_q == CMD_CYC_STOP) begin
        cyc_run_q <= 1'b0;
      end
      case (st_q)
        S_IDLE: begin
          if (issue) begin
            st_q <= S_WAIT;
            o_req_valid_q <= 1'b1;
            if (poll_pend_q) begin
              o_req_q <= '{kind: K_POLL, dev: poll_idx_q};
            end else if (go_data) begin
              o_req_q <= '{kind: K_DATA, dev: data_dev_q};
            end else if (go_brk) begin
              o_req_q <= '{kind: K_BRK, dev: '0};
            end else begin
              o_req_q <= '{kind: K_CYC, dev: nxt[5:0]};
              cyc_dev_q <= nxt[5:0];
              if (nxt[5:0] <= cyc_dev_q) begin
                round_ok_q <= 1'b1;
                round_cnt_q <= round_cnt_q + 1'b1;
                if (round_cnt_q == BRK_ROUNDS_M1) begin
                  brk_due_q <= 1'b1;
                end
              end
            end
          end
        end
        S_WAIT: begin
          if (i_rsp_valid) begin
            st_q <= S_IDLE;
            if (o_req_q.kind == K_POLL) begin
              poll_idx_q <= poll_idx_q + 1'b1;
              if (poll_idx_q == LAST_DEV) begin
                poll_pend_q <= 1'b0;
              end
            end
            if (o_req_q.kind == K_BRK) begin
              brk_due_q <= 1'b0;
            end
            // a retry or the next transfer waits for one more round
            if (o_req_q.kind == K_DATA) begin
              round_ok_q <= 1'b0;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // data transfer
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      data_pend_q <= 1'b0;
      data_dev_q <= '0;
      retry_q <= '0;
    end else if (send_cmd) begin
      data_pend_q <= 1'b1;
      data_dev_q <= ld_q[5:0];
      retry_q <= '0;
    end else if (rsp_data) begin
      retry_q <= retry_q + 1'b1;
      if (i_rsp.ok || data_fail_end) begin
        data_pend_q <= 1'b0;
      end
    end
  end

  sio_fifo #(.W(16), .D(FIFO_DEPTH)) u_txf (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_clr(1'b0),
    .i_push(wr_reg && (la_q == A_TXF_HI || (la_q == A_TXF_LO && !l8_q))),
    .i_wdata(l8_q ? {ld_q[7:0], lo_byte_q} : ld_q),
    .i_pop(i_tx_pop), .i_mark(issue_data), .i_rewind(data_rewind),
    .o_head(tx_head), .o_empty(tx_empty), .o_full(tx_full)
  );

  sio_fifo #(.W(16), .D(FIFO_DEPTH)) u_rxf (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_clr(send_cmd),
    .i_push(i_rx_valid), .i_wdata(i_rx_word),
    .i_pop(rd_done && la_q[9:1] == A_RXF[9:1] && (!l8_q || la_q[0])),
    .i_mark(1'b0), .i_rewind(1'b0),
    .o_head(rx_head), .o_empty(rx_empty), .o_full(rx_full)
  );

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lo_byte_q <= '0;
      o_tx_word_q <= '0;
      o_tx_empty_q <= 1'b1;
      cfg_q <= '0;
    end else begin
      if (wr_reg && la_q == A_TXF_LO && l8_q) begin
        lo_byte_q <= ld_q[7:0];
      end
      o_tx_word_q <= tx_head;
      o_tx_empty_q <= tx_empty;
      if (wr_reg && la_q == A_CFG) begin
        cfg_q <= ld_q;
      end
    end
  end

  // ------------------------------------------------------------
  // device info, ports, change and fault flags
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < NUM_DEV; i++) begin
        info_q[i] <= '0;
        fail_q[i] <= '0;
      end
      for (int p = 0; p < NUM_PORT; p++) begin
        port_q[p] <= '0;
      end
      chg_en_q <= '0;
      chg_q <= '0;
      fault_q <= '0;
    end else begin
      if (wr_info) begin
        info_q[adev] <= ld_q[7:0];
      end
      if (rsp_poll) begin
        info_q[o_req_q.dev] <= i_rsp.ok ? i_rsp.info : 8'h00;
      end
      if (wr_done && area == AREA_CHG && !la_q[7]) begin
        chg_en_q[{aword, 4'h0} +: 16] <= ld_q;
      end
      // write-back clear first so a same-cycle change still lands
      if (wr_done && area == AREA_CHG && la_q[7]) begin
        chg_q[{aword, 4'h0} +: 16] <= chg_q[{aword, 4'h0} +: 16] & ~ld_q;
      end
      if (wr_reg && la_q[9:3] == A_FAULT[9:3]) begin
        fault_q[{la_q[2:1], 4'h0} +: 16] <= fault_q[{la_q[2:1], 4'h0} +: 16] & ~ld_q;
      end
      if (rsp_cyc) begin
        if (i_rsp.ok) begin
          fail_q[o_req_q.dev] <= '0;
          port_q[{o_req_q.dev, 1'b0}] <= i_rsp.port0;
          port_q[{o_req_q.dev, 1'b1}] <= i_rsp.port1;
          if (chg_en_q[{o_req_q.dev, 1'b1}] && i_rsp.port1 != port_q[{o_req_q.dev, 1'b1}]) begin
            chg_q[{o_req_q.dev, 1'b1}] <= 1'b1;
          end
          if (chg_en_q[{o_req_q.dev, 1'b0}]) begin
            if (info_q[o_req_q.dev][INF_DATA]) begin
              if (i_rsp.port0[0] && !port_q[{o_req_q.dev, 1'b0}][0]) begin
                chg_q[{o_req_q.dev, 1'b0}] <= 1'b1;
              end
            end else if (i_rsp.port0 != port_q[{o_req_q.dev, 1'b0}]) begin
              chg_q[{o_req_q.dev, 1'b0}] <= 1'b1;
            end
          end
        end else if (fail_q[o_req_q.dev] == FAIL_LIMIT_M1) begin
          fail_q[o_req_q.dev] <= '0;
          fault_q[o_req_q.dev] <= 1'b1;
        end else begin
          fail_q[o_req_q.dev] <= fail_q[o_req_q.dev] + 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // status, read data, interrupt
  // ------------------------------------------------------------
  wire stat_rd = rd_done && la_q == A_CMD_STAT;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      done_q <= 1'b0;
      brk_q <= 1'b0;
    end else begin
      // read clears, but an event in the same cycle wins
      done_q <= (rsp_data && (i_rsp.ok || data_fail_end)) || (done_q && !stat_rd);
      brk_q <= (rsp_brk && i_rsp.break_detect_flag) || (brk_q && !stat_rd);
    end
  end

  logic [15:0] stat, rmux;
  always_comb begin
    stat = '0;
    stat[ST_DONE] = done_q;
    stat[ST_BRK] = brk_q;
    stat[ST_CHG] = |chg_q;
    stat[ST_FAULT] = |fault_q;
    stat[ST_RXP] = !rx_empty;
    stat[ST_CYC] = cyc_run_q;
    stat[ST_POLL] = poll_pend_q;
    case (hs.addr[9:8])
      AREA_INFO: rmux = {8'h00, info_q[hs.addr[6:1]]};
      AREA_CHG: rmux = hs.addr[7] ? chg_q[{hs.addr[3:1], 4'h0} +: 16] : chg_en_q[{hs.addr[3:1], 4'h0} +: 16];
      AREA_PORT: rmux = {port_q[{hs.addr[6:1], 1'b1}], port_q[{hs.addr[6:1], 1'b0}]};
      default: begin
        if (hs.addr[9:1] == A_CMD_STAT[9:1]) begin
          rmux = stat;
        end else if (hs.addr[9:1] == A_CFG[9:1]) begin
          rmux = cfg_q;
        end else if (hs.addr[9:1] == A_RXF[9:1]) begin
          rmux = rx_head;
        end else if (hs.addr[9:3] == A_FAULT[9:3]) begin
          rmux = fault_q[{hs.addr[2:1], 4'h0} +: 16];
        end else begin
          rmux = '0;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_d_q <= '0;
      o_d_oe_n_q <= 1'b1;
      o_irq_q <= 1'b0;
    end else begin
      o_d_q <= (hs.bus8 && hs.addr[0]) ? {8'h00, rmux[15:8]} : rmux;
      o_d_oe_n_q <= !rd_now;
      o_irq_q <= |(stat[6:0] & ~cfg_q[6:0]);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  AST_POLL_STEP: assert property (rsp_poll && poll_idx_q != LAST_DEV |=> poll_idx_q == $past(poll_idx_q) + 6'h01)
    else $error("poll index did not advance");
  AST_INFO_WRITE: assert property (wr_info && !rsp_poll |=> info_q[$past(adev)] == $past(ld_q[7:0]))
    else $error("host info write lost");
  AST_CYC_IN_USE: assert property (o_req_valid_q && o_req_q.kind == K_CYC |-> use_v[o_req_q.dev])
    else $error("cyclic request to unused device");
  AST_DATA_GATE: assert property (o_req_valid_q && o_req_q.kind == K_DATA |-> $past(round_ok_q && cyc_run_q))
    else $error("data transfer without a cyclic round");
  AST_DONE_SET: assert property (rsp_data && i_rsp.ok |=> done_q ##1 o_irq_q || cfg_q[ST_DONE])
    else $error("done flag or interrupt missing");
  AST_RX_CLEAR: assert property (send_cmd |=> !stat[ST_RXP])
    else $error("send command left rx fifo filled");
  AST_FAULT_THIRD: assert property (rsp_cyc && !i_rsp.ok && fail_q[o_req_q.dev] == FAIL_LIMIT_M1 |=> |fault_q)
    else $error("third failure did not flag fault");
  AST_NO_BRK_OFF: assert property (o_req_valid_q && o_req_q.kind == K_BRK |-> !$past(cfg_q[CFG_NOBRK]))
    else $error("break request while disabled");
  AST_IRQ_LEVEL: assert property (o_irq_q == $past(|(stat[6:0] & ~cfg_q[6:0])))
    else $error("interrupt level mismatch");

  COV_POLL_DONE: cover property (rsp_poll && poll_idx_q == LAST_DEV);
  COV_DATA_OK: cover property (rsp_data && i_rsp.ok);
  COV_FAULT: cover property (rsp_cyc && !i_rsp.ok ##1 |fault_q);
  COV_BRK: cover property (rsp_brk && i_rsp.break_detect_flag);
endmodule : sio_sched
`default_nettype wire

/* sio_far_model.sv */
// line framer and local device model facing the scheduler
`timescale 1ns/1ps
`default_nettype none
module sio_far_model
  import sio_pkg::*;
(
  input wire logic i_mclk,
  input wire sio_pkg::sio_req_t i_req,
  input wire logic i_req_valid,
  input wire logic [7:0] i_in0,
  output logic o_rsp_valid,
  output sio_pkg::sio_rsp_t o_rsp,
  output logic o_tx_pop,
  input wire logic [15:0] i_tx_word,
  input wire logic i_tx_empty,
  output logic o_rx_valid,
  output logic [15:0] o_rx_word
);
  logic [5:0] cyc_log[$];
  logic [5:0] poll_log[$];
  logic [15:0] tx_log[$];
  int slow = 0;
  int data_req = 0;
  logic held = 1'b0;
  initial begin
    o_rsp_valid = 1'b0;
    o_tx_pop = 1'b0;
    o_rx_valid = 1'b0;
    o_rsp = '0;
    o_rx_word = 16'h0000;
    forever begin
      @(posedge i_mclk);
      if (i_req_valid === 1'b1) begin
        // alternate prompt and slow answers
        slow = 4 - slow;
        repeat (1 + slow) @(posedge i_mclk);
        #1;
        o_rsp.ok = (i_req.dev != 6'h05) && !(i_req.kind == K_DATA && held);
        o_rsp.break_detect_flag = (i_req.kind == K_BRK);
        o_rsp.info = (i_req.dev == 6'h00) ? 8'h01 : (i_req.dev == 6'h02) ? 8'h03 : 8'h00;
        o_rsp.port0 = i_in0;
        o_rsp.port1 = 8'h00;
        if (i_req.kind == K_POLL) poll_log.push_back(i_req.dev);
        if (i_req.kind == K_CYC) cyc_log.push_back(i_req.dev);
        if (i_req.kind == K_DATA) begin
          data_req++;
          while (i_tx_empty === 1'b0) begin
            tx_log.push_back(i_tx_word);
            o_tx_pop = 1'b1;
            @(posedge i_mclk);
            #1;
            o_tx_pop = 1'b0;
            repeat (2) @(posedge i_mclk);
            #1;
          end
          // a device still holding its last block drops this one and stays silent
          if (held) begin
            held = 1'b0;
          end else begin
            held = 1'b1;
            o_rx_valid = 1'b1;
            o_rx_word = 16'hA5C3;
            @(posedge i_mclk);
            #1;
            o_rx_valid = 1'b0;
            o_rx_word = ~o_rx_word;
          end
        end
        o_rsp_valid = 1'b1;
        @(posedge i_mclk);
        #1;
        o_rsp_valid = 1'b0;
        // released lines must not keep the last value
        o_rsp = ~o_rsp;
      end
    end
  end
endmodule : sio_far_model
`default_nettype wire

/* test_serial_io_master_scheduler.sv */
// self-checking bench of the serial i/o scheduler
`timescale 1ns/1ps
`default_nettype none
module test_serial_io_master_scheduler;
  import sio_pkg::*;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  sio_host_t host = '{1'b1, 1'b1, 1'b1, 1'b0, 10'h000, 16'h0000};
  logic [15:0] d, txw, rxw, rd;
  logic oe_n, irq, req_v, rsp_v, pop, txe, rxv;
  logic [7:0] in0 = 8'h00;
  sio_req_t req;
  sio_rsp_t rsp;
  int err_count = 0;
  int tests_run = 0;
  logic [5:0] exp_dev[4] = '{6'h00, 6'h01, 6'h02, 6'h05};
  always #20 i_mclk = ~i_mclk;
  sio_sched dut_u (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_host(host), .o_d_q(d), .o_d_oe_n_q(oe_n),
    .o_irq_q(irq), .o_req_q(req), .o_req_valid_q(req_v), .i_rsp_valid(rsp_v), .i_rsp(rsp), .i_tx_pop(pop),
    .o_tx_word_q(txw), .o_tx_empty_q(txe), .i_rx_valid(rxv), .i_rx_word(rxw));
  sio_far_model far_u (.i_mclk(i_mclk), .i_req(req), .i_req_valid(req_v), .i_in0(in0), .o_rsp_valid(rsp_v),
    .o_rsp(rsp), .o_tx_pop(pop), .i_tx_word(txw), .i_tx_empty(txe), .o_rx_valid(rxv), .o_rx_word(rxw));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic [9:0] a, input logic [15:0] v, input logic wr, input logic b8);
    @(posedge i_mclk);
    #1;
    host.addr = a;
    host.data = v;
    host.bus8 = b8;
    host.cs_n = 1'b0;
    host.wr_n = ~wr;
    host.rd_n = wr;
    repeat (4) @(posedge i_mclk);
    #1;
    rd = d;
    host.cs_n = 1'b1;
    host.wr_n = 1'b1;
    host.rd_n = 1'b1;
    // address held past the strobe for the sync delay
    repeat (4) @(posedge i_mclk);
  endtask : acc
  task automatic wait_irq(input logic v);
    for (int n = 0; n < 3000 && irq !== v; n++) begin
      @(posedge i_mclk);
      #1;
    end
  endtask : wait_irq
  task automatic end_sim();
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic run_poll(input int n);
    acc(A_CMD_STAT, CMD_POLL, 1'b1, 1'b0);
    for (int k = 0; k < 100; k++) begin
      acc(A_CMD_STAT, 16'h0000, 1'b0, 1'b0);
      if (rd[ST_POLL] === 1'b0) break;
    end
    chk(16'(far_u.poll_log.size()), 16'(n));
  endtask : run_poll
  task automatic t_poll();
    run_poll(64);
    for (int i = 0; i < 64; i++) chk(16'(far_u.poll_log[i]), 16'(i));
    acc(10'h100, 16'h0000, 1'b0, 1'b0);
    chk(rd, 16'h0001);
    acc(10'h104, 16'h0000, 1'b0, 1'b0);
    chk(rd, 16'h0003);
  endtask : t_poll
  task automatic t_cyclic();
    int n0;
    acc(10'h102, 16'h0001, 1'b1, 1'b0);
    acc(10'h10A, 16'h0001, 1'b1, 1'b0);
    acc(10'h200, 16'h0011, 1'b1, 1'b0);
    acc(A_CFG, 16'h0008, 1'b1, 1'b0);
    acc(A_CMD_STAT, CMD_CYC_START, 1'b1, 1'b0);
    repeat (300) @(posedge i_mclk);
    #1;
    in0 = 8'h01;
    wait_irq(1'b1);
    chk(16'(irq), 16'h0001);
    // give the data device on 2 a round to see the rise as well
    repeat (60) @(posedge i_mclk);
    acc(10'h280, 16'h0000, 1'b0, 1'b0);
    chk(rd, 16'h0011);
    acc(10'h280, 16'h0011, 1'b1, 1'b0);
    wait_irq(1'b0);
    chk(16'(irq), 16'h0000);
    acc(A_CFG, 16'h000C, 1'b1, 1'b0);
    #1;
    in0 = 8'h00;
    repeat (300) @(posedge i_mclk);
    #1;
    chk(16'(irq), 16'h0000);
    acc(10'h280, 16'h0000, 1'b0, 1'b0);
    chk(rd, 16'h0001);
    acc(A_CMD_STAT, 16'h0000, 1'b0, 1'b0);
    chk(16'({rd[ST_CYC], rd[ST_FAULT], rd[ST_CHG]}), 16'h0007);
    acc(A_FAULT, 16'h0000, 1'b0, 1'b0);
    chk(rd, 16'h0020);
    for (int i = 0; i < 8; i++) chk(16'(far_u.cyc_log[i]), 16'(exp_dev[i % 4]));
    run_poll(128);
    n0 = far_u.cyc_log.size();
    acc(10'h102, 16'h0000, 1'b0, 1'b0);
    chk(rd, 16'h0000);
    repeat (60) @(posedge i_mclk);
    chk(16'(far_u.cyc_log.size() > n0), 16'h0001);
  endtask : t_cyclic
  task automatic t_data();
    acc(A_TXF_LO, 16'h0090, 1'b1, 1'b0);
    acc(A_TXF_LO, 16'h4567, 1'b1, 1'b0);
    acc(A_TXF_LO, 16'h0123, 1'b1, 1'b0);
    acc(A_CMD_STAT, 16'h4002, 1'b1, 1'b0);
    wait_irq(1'b1);
    chk(16'(irq), 16'h0001);
    acc(A_CMD_STAT, 16'h0000, 1'b0, 1'b0);
    chk(16'({rd[ST_RXP], rd[ST_DONE]}), 16'h0003);
    acc(A_RXF, 16'h0000, 1'b0, 1'b0);
    chk(rd, 16'hA5C3);
    acc(A_CMD_STAT, 16'h0000, 1'b0, 1'b0);
    chk(16'(rd[ST_RXP]), 16'h0000);
    acc(A_TXF_LO, 16'h0034, 1'b1, 1'b1);
    acc(A_TXF_HI, 16'h0012, 1'b1, 1'b1);
    acc(A_CMD_STAT, 16'h4002, 1'b1, 1'b0);
    wait_irq(1'b1);
    acc(A_CMD_STAT, CMD_CYC_STOP, 1'b1, 1'b0);
    chk(16'(far_u.tx_log.size()), 16'h0005);
    chk(far_u.tx_log[0], 16'h0090);
    chk(far_u.tx_log[2], 16'h0123);
    chk(far_u.tx_log[3], 16'h1234);
    chk(far_u.tx_log[4], 16'h1234);
    chk(16'(far_u.data_req), 16'h0003);
  endtask : t_data
  initial begin
    repeat (12) @(posedge i_mclk);
    #1;
    chk(16'({irq, oe_n, txe}), 16'h0003);
    i_arst_n = 1'b1;
    t_poll();
    t_cyclic();
    t_data();
    end_sim();
  end
  initial begin
    #2000000;
    err_count++;
    end_sim();
  end
endmodule : test_serial_io_master_scheduler
`default_nettype wire
